//--- core/ldfc_consts.vh
`ifndef LDFC_CONSTS_VH
`define LDFC_CONSTS_VH

// Register addresses on the serial interface.
`define LDFC_ADDR_LOCK_SEL    7'h3d
`define LDFC_ADDR_RSVD_WORD   7'h3e
`define LDFC_ADDR_FAST_CAL    7'h40

// Reset values (reserved bits reset to zero).
`define LDFC_RST_LOCK_SEL     16'h0001
`define LDFC_RST_RSVD_WORD    16'h0000
`define LDFC_RST_FAST_CAL     16'h006f

// Field positions.
`define LDFC_BIT_LOCK_KIND    0
`define LDFC_BIT_QUICK_AMPLITUDE_CAL_ENABLE    9
`define LDFC_BIT_QUICK_FREQUENCY_CAL_ENABLE    8
`define LDFC_AJUMP_MSB        7
`define LDFC_AJUMP_LSB        5
`define LDFC_FJUMP_MSB        3
`define LDFC_FJUMP_LSB        0

// Serial frame layout: one direction bit, seven address bits, sixteen data bits.
`define LDFC_FRAME_BITS       5'd24
`define LDFC_HDR_BITS         5'd8
`define LDFC_MUX_LOCK_DETECT  1'b1

`endif

//--- core/ldfc_sync2.v
`timescale 1ns/1ps

// Two-stage synchroniser for signals arriving from outside the clock domain.
module ldfc_sync2 #(
  parameter             WIDTH   = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Each bit resets to the idle level of the pin it follows.
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

//--- core/ldfc_regs.v
// Overview of operation
// R1: Lock kind bit 0 defaults 1; shown on status pin only when pin select is 1.
// R2: Kind 0: status pin goes high once automatic calibration completed successfully.
// R3: Kind 1: status pin high when tuning voltage in range, low otherwise.
// R4: Bit 9 of calibration register enables fast amplitude calibration, reset 0.
// R5: Bit 8 of calibration register enables fast frequency calibration, reset 0.
// R6: Bits 7:5, default 3, amplitude jump step, effective only with fast amplitude.
// R7: Bits 3:0, default 15, frequency jump step, effective only with fast frequency.
// R8: Host writes all unnamed bits with their register-map default values.
`timescale 1ns/1ps
`include "ldfc_consts.vh"

module ldfc_regs (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // Four-wire serial programming interface
  input  wire       spi_csb_n,
  input  wire       spi_sck,
  input  wire       spi_sdi,
  output reg        spi_sdo,
  output reg        spi_sdo_oe,
  // Status sources from the synthesizer core
  input  wire       cal_done,
  input  wire       vtune_in_range,
  input  wire       status_pin_source_select,
  // Status pin
  output reg        status_output_pin,
  // Calibration controls
  output reg        quick_amplitude_cal_enable,
  output reg        quick_frequency_cal_enable,
  output reg  [2:0] amplitude_cal_step,
  output reg  [3:0] frequency_cal_step
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  wire [5:0] sync_bus;
  wire       csb_s;
  wire       sck_s;
  wire       sdi_s;
  wire       cal_done_s;
  wire       vtune_s;
  wire       sel_s;

  // Chip select resets to its idle high level so that no false frame start
  // is seen while the synchronisers fill after reset.
  ldfc_sync2 #(.WIDTH(6), .RST_VAL(6'h01)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({status_pin_source_select, vtune_in_range, cal_done,
                spi_sdi, spi_sck, spi_csb_n}),
    .sync_out (sync_bus)
  );

  assign csb_s      = sync_bus[0];
  assign sck_s      = sync_bus[1];
  assign sdi_s      = sync_bus[2];
  assign cal_done_s = sync_bus[3];
  assign vtune_s    = sync_bus[4];
  assign sel_s      = sync_bus[5];

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  // The serial clock is oversampled by mclk, so it must run well below
  // a quarter of mclk for both edges to be seen.
  // A frame is a direction bit, seven address bits and sixteen data bits,
  // most significant bit first. Raising chip select early drops the frame,
  // and clock edges after the twenty-fourth are ignored.
  reg        sck_d_reg;
  reg [4:0]  bit_cnt_reg;
  reg [22:0] shift_reg;
  reg        read_reg;
  reg [15:0] rd_shift_reg;
  reg [15:0] lock_sel_reg;
  reg [15:0] rsvd_word_reg;
  reg [15:0] fast_cal_reg;

  wire       sck_rise;
  wire       sck_fall;
  wire       active;
  wire [4:0] bit_cnt_next;
  wire [6:0] addr_next;
  wire       frame_done;
  wire       hdr_done;

  assign sck_rise     = sck_s & ~sck_d_reg;
  assign sck_fall     = ~sck_s & sck_d_reg;
  assign active       = ~csb_s;
  assign bit_cnt_next = bit_cnt_reg + 5'd1;
  assign hdr_done     = active & sck_rise & (bit_cnt_next == `LDFC_HDR_BITS);
  assign frame_done   = active & sck_rise & (bit_cnt_next == `LDFC_FRAME_BITS);
  assign addr_next    = {shift_reg[5:0], sdi_s};

  // ----------------------------------------
  // Read-back selection
  // ----------------------------------------
  // Read data selected by the address gathered so far.
  reg [15:0] rd_data;
  always @* begin
    if (addr_next == `LDFC_ADDR_LOCK_SEL) begin
      rd_data = lock_sel_reg;
    end else if (addr_next == `LDFC_ADDR_RSVD_WORD) begin
      rd_data = rsvd_word_reg;
    end else if (addr_next == `LDFC_ADDR_FAST_CAL) begin
      rd_data = fast_cal_reg;
    end else begin
      rd_data = 16'h0000;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_reg    <= 1'b0;
      bit_cnt_reg  <= 5'd0;
      shift_reg    <= 23'h000000;
      read_reg     <= 1'b0;
      rd_shift_reg <= 16'h0000;
      spi_sdo      <= 1'b0;
      spi_sdo_oe   <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      if (!active) begin
        bit_cnt_reg <= 5'd0;
        read_reg    <= 1'b0;
        spi_sdo_oe  <= 1'b0;
        spi_sdo     <= 1'b0;
      end else begin
        if (sck_rise && bit_cnt_reg != `LDFC_FRAME_BITS) begin
          bit_cnt_reg <= bit_cnt_next;
          shift_reg   <= {shift_reg[21:0], sdi_s};
          if (bit_cnt_reg == 5'd0) begin
            read_reg <= sdi_s;
          end
        end
        if (hdr_done && read_reg) begin
          rd_shift_reg <= rd_data;
        end
        // Read data leaves on falling edges so the host samples it on rising ones.
        if (sck_fall && read_reg && bit_cnt_reg >= `LDFC_HDR_BITS &&
            bit_cnt_reg != `LDFC_FRAME_BITS) begin
          spi_sdo      <= rd_shift_reg[15];
          spi_sdo_oe   <= 1'b1;
          rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Reserved bits are stored as written; the host keeps them at defaults. [R8]
  wire [15:0] wr_data;
  wire [6:0]  wr_addr;
  wire        wr_lock_hit;
  wire        wr_rsvd_hit;
  wire        wr_cal_hit;
  assign wr_data = {shift_reg[14:0], sdi_s};
  assign wr_addr = shift_reg[21:15];
  // Writes commit on the twenty-fourth serial clock rise; reads never write.
  assign wr_lock_hit = frame_done & ~read_reg & (wr_addr == `LDFC_ADDR_LOCK_SEL);
  assign wr_rsvd_hit = frame_done & ~read_reg & (wr_addr == `LDFC_ADDR_RSVD_WORD);
  assign wr_cal_hit  = frame_done & ~read_reg & (wr_addr == `LDFC_ADDR_FAST_CAL);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_sel_reg  <= `LDFC_RST_LOCK_SEL;  // [R1]
      rsvd_word_reg <= `LDFC_RST_RSVD_WORD;
      fast_cal_reg  <= `LDFC_RST_FAST_CAL;  // [R4] [R5] [R6] [R7]
    end else begin
      if (wr_lock_hit) begin
        lock_sel_reg <= wr_data;
      end else if (wr_rsvd_hit) begin
        rsvd_word_reg <= wr_data;
      end else if (wr_cal_hit) begin
        fast_cal_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Status pin and calibration controls
  // ----------------------------------------
  // A disabled fast mode presents a zero step so the calibrator cannot
  // pick up a stale increment.
  // Status sources pass the two-flop synchroniser and this register, so
  // the pin trails its source by three clock edges.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_output_pin          <= 1'b0;
      quick_amplitude_cal_enable <= 1'b0;
      quick_frequency_cal_enable <= 1'b0;
      amplitude_cal_step         <= 3'h0;
      frequency_cal_step         <= 4'h0;
    end else begin
      if (sel_s == `LDFC_MUX_LOCK_DETECT) begin  // [R1]
        if (lock_sel_reg[`LDFC_BIT_LOCK_KIND]) begin
          status_output_pin <= vtune_s;  // [R3]
        end else begin
          status_output_pin <= cal_done_s;  // [R2]
        end
      end else begin
        status_output_pin <= 1'b0;
      end
      quick_amplitude_cal_enable <= fast_cal_reg[`LDFC_BIT_QUICK_AMPLITUDE_CAL_ENABLE];  // [R4]
      quick_frequency_cal_enable <= fast_cal_reg[`LDFC_BIT_QUICK_FREQUENCY_CAL_ENABLE];  // [R5]
      if (fast_cal_reg[`LDFC_BIT_QUICK_AMPLITUDE_CAL_ENABLE]) begin
        amplitude_cal_step <= fast_cal_reg[`LDFC_AJUMP_MSB:`LDFC_AJUMP_LSB];  // [R6]
      end else begin
        amplitude_cal_step <= 3'h0;
      end
      if (fast_cal_reg[`LDFC_BIT_QUICK_FREQUENCY_CAL_ENABLE]) begin
        frequency_cal_step <= fast_cal_reg[`LDFC_FJUMP_MSB:`LDFC_FJUMP_LSB];  // [R7]
      end else begin
        frequency_cal_step <= 4'h0;
      end
    end
  end

endmodule

//--- bench/ldfc_monitor.sv
`timescale 1ns/1ps
module ldfc_monitor (
  // Clock, reset and status inputs
  input wire       mclk,
  input wire       rst_n,
  input wire       cal_done,
  input wire       vtune_in_range,
  input wire       status_pin_source_select,
  // Design outputs
  input wire       status_output_pin,
  input wire       quick_amplitude_cal_enable,
  input wire       quick_frequency_cal_enable,
  input wire [2:0] amplitude_cal_step,
  input wire [3:0] frequency_cal_step
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Five samples cover the input synchronisers plus the pin register.
  pin_off_a: assert property (!status_pin_source_select [*5] |-> !status_output_pin)
    else $error("status pin high while not selected");
  idle_low_a: assert property (
    (!cal_done && !vtune_in_range) [*5] |-> !status_output_pin)
    else $error("status pin high without a cause");
  source_agree_a: assert property (
    (status_pin_source_select && cal_done == vtune_in_range) [*5]
    |-> status_output_pin == vtune_in_range)
    else $error("status pin disagrees with both sources");
  amp_reset_a: assert property ($rose(rst_n) |-> !quick_amplitude_cal_enable)
    else $error("amplitude enable set after reset");
  freq_reset_a: assert property ($rose(rst_n) |-> !quick_frequency_cal_enable)
    else $error("frequency enable set after reset");
  amp_gate_a: assert property (!quick_amplitude_cal_enable |-> amplitude_cal_step == 3'h0)
    else $error("amplitude step live while disabled");
  freq_gate_a: assert property (!quick_frequency_cal_enable |-> frequency_cal_step == 4'h0)
    else $error("frequency step live while disabled");
endmodule
bind ldfc_regs ldfc_monitor mon (.mclk(mclk), .rst_n(rst_n), .cal_done(cal_done),
  .vtune_in_range(vtune_in_range), .status_pin_source_select(status_pin_source_select),
  .status_output_pin(status_output_pin), .quick_amplitude_cal_enable(quick_amplitude_cal_enable),
  .quick_frequency_cal_enable(quick_frequency_cal_enable),
  .amplitude_cal_step(amplitude_cal_step), .frequency_cal_step(frequency_cal_step));

//--- bench/ldfc_host.sv
`timescale 1ns/1ps
module ldfc_host (
  // Serial pins
  input  wire mclk,
  input  wire sdo,
  output reg  csb_n,
  output reg  sck,
  output reg  sdi
);
  initial begin
    csb_n = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b0;
  end
  // Long clock phases leave room for the device's input synchronisers.
  task xfer(input rd, input [6:0] a, input [15:0] wd, output [15:0] q);
    reg [23:0] f;
    integer    i;
    begin
      f = {rd, a, wd};
      q = 16'h0000;
      @(posedge mclk) csb_n <= 1'b0;
      for (i = 23; i >= 0; i = i - 1) begin
        @(posedge mclk) sck <= 1'b0;
        sdi <= f[i];
        repeat (6) @(posedge mclk);
        if (i < 16) q[i] = sdo;
        sck <= 1'b1;
        repeat (5) @(posedge mclk);
      end
      @(posedge mclk) sck <= 1'b0;
      repeat (6) @(posedge mclk);
      csb_n <= 1'b1;
      sdi   <= ~sdi;
      repeat (6) @(posedge mclk);
    end
  endtask
endmodule

//--- bench/lock_detect_fast_cal_regs_tb.sv
`timescale 1ns/1ps
`include "ldfc_consts.vh"
module lock_detect_fast_cal_regs_tb;
  reg         mclk;
  reg         rst_n;
  reg         cal;
  reg         vt;
  reg         sel;
  wire        csb_n;
  wire        sck;
  wire        sdi;
  wire        sdo;
  wire        oe;
  wire        sdo_line;
  wire        pin;
  wire        ae;
  wire        fe;
  wire [2:0]  as;
  wire [3:0]  fs;
  reg  [15:0] q;
  integer     fails;
  integer     checks;
  integer     cyc;
  // A released data line shows the inverse of the last bit, so a late enable is caught.
  assign sdo_line = oe ? sdo : ~sdo;
  ldfc_host host (.mclk(mclk), .sdo(sdo_line), .csb_n(csb_n), .sck(sck), .sdi(sdi));
  ldfc_regs dut (.mclk(mclk), .rst_n(rst_n), .spi_csb_n(csb_n), .spi_sck(sck),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .cal_done(cal), .vtune_in_range(vt),
    .status_pin_source_select(sel), .status_output_pin(pin),
    .quick_amplitude_cal_enable(ae), .quick_frequency_cal_enable(fe),
    .amplitude_cal_step(as), .frequency_cal_step(fs));
  always #5 mclk = ~mclk;
  task check(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [15:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task rd(input [6:0] a, input [15:0] exp);
    begin
      host.xfer(1'b1, a, 16'h0000, q);
      check(q, exp);
      check({15'h0, oe}, 16'h0000);
    end
  endtask
  task wt;
    begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // A hang counts as a mismatch.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      complete_run;
    end
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    cal = 1'b0;
    vt = 1'b0;
    sel = 1'b0;
    fails = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(7'h3d, 16'h0001);
    rd(7'h3e, 16'h0000);
    rd(7'h40, 16'h006f);
    rd(7'h41, 16'h0000);
    check({7'h0, ae, fe, as, fs}, 16'h0000);
    $display("reset values done");
    wr(7'h40, 16'h03ef);
    wt;
    check({7'h0, ae, fe, as, fs}, 16'h01ff);
    wr(7'h40, 16'h0245);
    wt;
    check({7'h0, ae, fe, as, fs}, 16'h0120);
    rd(7'h40, 16'h0245);
    $display("fast calibration done");
    @(posedge mclk) sel <= 1'b1;
    cal <= 1'b1;
    wr(7'h3d, 16'h0000);
    wt;
    check({15'h0, pin}, 16'h0001);
    wr(7'h3d, 16'h0001);
    wt;
    check({15'h0, pin}, 16'h0000);
    @(posedge mclk) vt <= 1'b1;
    wt;
    check({15'h0, pin}, 16'h0001);
    @(posedge mclk) sel <= 1'b0;
    wt;
    check({15'h0, pin}, 16'h0000);
    $display("status pin done");
    @(posedge mclk) rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(7'h40, 16'h006f);
    rd(7'h3d, 16'h0001);
    check({7'h0, ae, fe, as, fs}, 16'h0000);
    $display("second reset done");
    complete_run;
  end
endmodule
